//--- common/lvfs_params.svh
/*
 Constants of the low-side fault status register: field positions,
 reset values and timing counts. Assumes inclusion by bare name.
*/
`ifndef LVFS_PARAMS_SVH
`define LVFS_PARAMS_SVH

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LVFS_BIT_LOGIC_UV   7
`define LVFS_BIT_CTRL_UV    6
`define LVFS_BIT_DEADTIME   4
`define LVFS_BIT_SERIAL     3
`define LVFS_BIT_CFG_PEND   1
`define LVFS_BIT_FLYBACK    0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define LVFS_RST_FULL       8'h02
`define LVFS_RST_FLAG       1'b0
`define LVFS_RST_PEND       1'b1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LVFS_SYNC_STAGES    3
`define LVFS_CLK_MHZ        20

`endif

//--- common/lvfs_pkg.sv
/*
 Types of the low-side fault status register.
 Assumes the params header is on the include path.
*/
package lvfs_pkg;
   typedef logic [7:0] lvfs_byte_type;
   typedef enum logic [2:0] {
      LVFS_ST_RESET = 3'h1,
      LVFS_ST_RUN   = 3'h2,
      LVFS_ST_CLEAR = 3'h4
   } lvfs_state_type;
endpackage : lvfs_pkg

//--- design/lvfs_sync.sv
/*
 Three-stage input synchroniser with agreement of stages two and three.
 Assumes the input is asynchronous to i_clk.
*/
`timescale 1ns/1ps
module lvfs_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   // Data
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] o_sync_next;

   assign agree       = ~(s2_reg ^ s3_reg);
   assign o_sync_next = (agree & s2_reg) | (~agree & o_sync);

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         o_sync <= '0;
      end else begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         o_sync <= o_sync_next;
      end
   end
endmodule : lvfs_sync

//--- design/lvfs_status.sv
/*
 Low-side fault status register of an isolated gate driver.
 Assumes the serial command decoder on i_clk delivers one-cycle event
 pulses, and that supply, deadtime and flyback fault levels come from
 pins asynchronous to i_clk. i_rst_b is the power-on reset.
*/
// Summary of operation
// - Logic-supply undervoltage sets bit 7, latched, forcing the safe state.
// - Control-supply undervoltage shows in bit 6 live, masked during logic undervoltage.
// - Flyback controller held stopped while control-supply undervoltage is present.
// - Deadtime violation sets bit 4, latched, no safe state.
// - Any serial error event sets bit 3, latched.
// - Config-pending bit 1 set by soft reset, power-on, begin-config command.
// - Config-pending cleared only by good end-config after completed procedure.
// - Bit 0 follows flyback fault live, no latch, no safe state.
// - Status clear zeroes latched bits 7,4,3 and keeps config-pending; live bits 6,0 are unaffected.
// - Status clear comes from reset-status command or shutdown-pin reset.
// - Soft-reset command performs a soft reset of the register.
// - Power-on reset loads the full reset values.
// - Present faults override defaults immediately after any status clear or soft reset.
// - Register is read-only; all flags active high.
`timescale 1ns/1ps
`include "lvfs_params.svh"
module lvfs_status (
   // Clock and power-on reset
   input  wire logic               i_clk,
   input  wire logic               i_rst_b,
   // Asynchronous fault levels
   input  wire logic               i_logic_supply_uv,
   input  wire logic               i_ctrl_supply_uv,
   input  wire logic               i_deadtime_violation,
   input  wire logic               i_flyback_fault,
   // Serial decoder events (one-cycle pulses)
   input  wire logic               i_reset_status_command,
   input  wire logic               i_shutdown_pin_reset,
   input  wire logic               i_soft_reset_command,
   input  wire logic               i_begin_configuration_command,
   input  wire logic               i_end_configuration_command,
   input  wire logic               i_config_procedure_ok,
   input  wire logic               i_crc_error,
   input  wire logic               i_clock_count_error,
   input  wire logic               i_command_error,
   input  wire logic               i_procedure_error,
   input  wire logic               i_config_timer_expired,
   input  wire logic               i_address_error,
   // Register read data and controls
   output lvfs_pkg::lvfs_byte_type o_lv_fault_status_three,
   output logic                    o_forced_safe_state,
   output logic                    o_flyback_stop
);
   import lvfs_pkg::*;

   // ---------------------------------------------------------------
   // Synchronised fault levels
   // ---------------------------------------------------------------
   logic [3:0] flt_sync;
   logic       logic_uv;
   logic       ctrl_uv;
   logic       dt_viol;
   logic       fly_flt;

   lvfs_sync #(
      .WIDTH (4)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_async ({i_logic_supply_uv, i_ctrl_supply_uv,
                 i_deadtime_violation, i_flyback_fault}),
      .o_sync  (flt_sync)
   );

   assign logic_uv = flt_sync[3];
   assign ctrl_uv  = flt_sync[2];
   assign dt_viol  = flt_sync[1];
   assign fly_flt  = flt_sync[0];

   // ---------------------------------------------------------------
   // Event decode
   // ---------------------------------------------------------------
   logic status_clear;
   logic soft_reset;
   logic serial_error;
   logic cfg_set;
   logic cfg_done;

   assign status_clear = i_reset_status_command | i_shutdown_pin_reset;
   assign soft_reset   = i_soft_reset_command;
   assign serial_error = i_crc_error | i_clock_count_error | i_command_error
                       | i_procedure_error | i_config_timer_expired
                       | i_address_error;
   assign cfg_set      = soft_reset | i_begin_configuration_command;
   assign cfg_done     = i_end_configuration_command & i_config_procedure_ok;

   // ---------------------------------------------------------------
   // Flag state
   // ---------------------------------------------------------------
   logic logic_supply_undervoltage_flag_reg;
   logic logic_supply_undervoltage_flag_next;
   logic control_supply_undervoltage_flag_reg;
   logic control_supply_undervoltage_flag_next;
   logic deadtime_violation_flag_reg;
   logic deadtime_violation_flag_next;
   logic serial_error_flag_reg;
   logic serial_error_flag_next;
   logic low_side_config_pending_flag_reg;
   logic low_side_config_pending_flag_next;
   logic isolated_supply_ctrl_fault_bit_reg;
   logic isolated_supply_ctrl_fault_bit_next;
   logic wipe;
   logic safe_next;
   logic stop_next;
   lvfs_byte_type status_next;

   assign wipe = status_clear | soft_reset;

   // Latched flags: a present cause wins over clear
   assign logic_supply_undervoltage_flag_next = logic_uv
          | (logic_supply_undervoltage_flag_reg & ~wipe);
   assign deadtime_violation_flag_next = dt_viol
          | (deadtime_violation_flag_reg & ~wipe);
   assign serial_error_flag_next = serial_error
          | (serial_error_flag_reg & ~wipe);
   // Live flags
   assign control_supply_undervoltage_flag_next = ctrl_uv & ~logic_uv;
   assign isolated_supply_ctrl_fault_bit_next   = fly_flt;
   // Pending: set wins; status clear leaves it alone
   assign low_side_config_pending_flag_next = cfg_set
          | (low_side_config_pending_flag_reg & ~cfg_done);

   assign safe_next = logic_supply_undervoltage_flag_next;
   assign stop_next = ctrl_uv;

   assign status_next = {logic_supply_undervoltage_flag_next,
                         control_supply_undervoltage_flag_next,
                         1'b0,
                         deadtime_violation_flag_next,
                         serial_error_flag_next,
                         1'b0,
                         low_side_config_pending_flag_next,
                         isolated_supply_ctrl_fault_bit_next};

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         logic_supply_undervoltage_flag_reg   <= `LVFS_RST_FLAG;
         control_supply_undervoltage_flag_reg <= `LVFS_RST_FLAG;
         deadtime_violation_flag_reg          <= `LVFS_RST_FLAG;
         serial_error_flag_reg                <= `LVFS_RST_FLAG;
         low_side_config_pending_flag_reg     <= `LVFS_RST_PEND;
         isolated_supply_ctrl_fault_bit_reg   <= `LVFS_RST_FLAG;
         o_lv_fault_status_three              <= `LVFS_RST_FULL;
         o_forced_safe_state                  <= 1'b0;
         o_flyback_stop                       <= 1'b0;
      end else begin
         logic_supply_undervoltage_flag_reg   <= logic_supply_undervoltage_flag_next;
         control_supply_undervoltage_flag_reg <= control_supply_undervoltage_flag_next;
         deadtime_violation_flag_reg          <= deadtime_violation_flag_next;
         serial_error_flag_reg                <= serial_error_flag_next;
         low_side_config_pending_flag_reg     <= low_side_config_pending_flag_next;
         isolated_supply_ctrl_fault_bit_reg   <= isolated_supply_ctrl_fault_bit_next;
         o_lv_fault_status_three              <= status_next;
         o_forced_safe_state                  <= safe_next;
         o_flyback_stop                       <= stop_next;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   chk_logic_uv_latch: assert property (
      logic_uv && !$past(!i_rst_b) |=> o_lv_fault_status_three[7] && o_forced_safe_state)
      else $error("logic undervoltage not latched");
   chk_ctrl_uv_mask: assert property (
      logic_uv |=> !o_lv_fault_status_three[6])
      else $error("control undervoltage not masked");
   chk_flyback_stop: assert property (
      ctrl_uv |=> o_flyback_stop)
      else $error("flyback not stopped");
   chk_dt_no_safe: assert property (
      dt_viol && !logic_supply_undervoltage_flag_next |=>
         o_lv_fault_status_three[4] && !o_forced_safe_state)
      else $error("deadtime flag wrong");
   chk_serial_err_set: assert property (
      serial_error |=> o_lv_fault_status_three[3])
      else $error("serial error not flagged");
   chk_pend_set: assert property (
      cfg_set |=> o_lv_fault_status_three[1])
      else $error("config pending not set");
   chk_pend_hold: assert property (
      low_side_config_pending_flag_reg && !cfg_done |=> low_side_config_pending_flag_reg)
      else $error("config pending cleared wrongly");
   chk_flyback_live: assert property (
      ##1 o_lv_fault_status_three[0] == $past(fly_flt))
      else $error("flyback bit not live");
   chk_clear_wipes: assert property (
      status_clear && !serial_error && !cfg_set && !cfg_done |=>
         o_lv_fault_status_three[3] == 1'b0 &&
         low_side_config_pending_flag_reg == $past(low_side_config_pending_flag_reg))
      else $error("status clear wrong");
   chk_latch_holds: assert property (
      deadtime_violation_flag_reg && !wipe |=> deadtime_violation_flag_reg [*1])
      else $error("latched flag dropped");
   chk_unused_zero: assert property (
      o_lv_fault_status_three[5] == 1'b0 && o_lv_fault_status_three[2] == 1'b0)
      else $error("unused bits nonzero");

   // ---------------------------------------------------------------
   // Latched flag checks
   // ---------------------------------------------------------------
   chk_logic_uv_hold: assert property (
      logic_supply_undervoltage_flag_reg && !wipe |=> logic_supply_undervoltage_flag_reg)
      else $error("logic undervoltage flag dropped");

   chk_serial_hold: assert property (
      serial_error_flag_reg && !wipe |=> serial_error_flag_reg)
      else $error("serial error flag dropped");

   chk_safe_mirror: assert property (
      o_forced_safe_state == o_lv_fault_status_three[`LVFS_BIT_LOGIC_UV])
      else $error("safe state differs from logic undervoltage flag");

   chk_dt_set: assert property (
      dt_viol |=> o_lv_fault_status_three[`LVFS_BIT_DEADTIME])
      else $error("deadtime flag not set");

   chk_logic_uv_clear: assert property (
      wipe && !logic_uv |=>
         !o_lv_fault_status_three[`LVFS_BIT_LOGIC_UV] && !o_forced_safe_state)
      else $error("logic undervoltage flag not cleared");

   chk_dt_clear: assert property (
      wipe && !dt_viol |=> !o_lv_fault_status_three[`LVFS_BIT_DEADTIME])
      else $error("deadtime flag not cleared");

   chk_serial_clear: assert property (
      wipe && !serial_error |=> !o_lv_fault_status_three[`LVFS_BIT_SERIAL])
      else $error("serial error flag not cleared");

   chk_dt_override: assert property (
      wipe && dt_viol |=> o_lv_fault_status_three[`LVFS_BIT_DEADTIME])
      else $error("present deadtime lost on clear");

   chk_serial_override: assert property (
      wipe && serial_error |=> o_lv_fault_status_three[`LVFS_BIT_SERIAL])
      else $error("serial error lost on clear");

   // ---------------------------------------------------------------
   // Live flag checks
   // ---------------------------------------------------------------
   chk_ctrl_uv_live: assert property (
      ##1 o_lv_fault_status_three[`LVFS_BIT_CTRL_UV] == $past(ctrl_uv && !logic_uv))
      else $error("control undervoltage bit not live");

   chk_flyback_run: assert property (
      !ctrl_uv |=> !o_flyback_stop)
      else $error("flyback stopped without undervoltage");

   chk_live_no_safe: assert property (
      !logic_supply_undervoltage_flag_next |=> !o_forced_safe_state)
      else $error("safe state forced by a live flag");

   chk_live_mirror: assert property (
      o_lv_fault_status_three[`LVFS_BIT_CTRL_UV] == control_supply_undervoltage_flag_reg &&
      o_lv_fault_status_three[`LVFS_BIT_FLYBACK] == isolated_supply_ctrl_fault_bit_reg)
      else $error("live bits differ from flag state");

   // ---------------------------------------------------------------
   // Configuration pending checks
   // ---------------------------------------------------------------
   chk_pend_begin: assert property (
      i_begin_configuration_command |=> o_lv_fault_status_three[`LVFS_BIT_CFG_PEND])
      else $error("begin command did not set pending");

   chk_pend_clear: assert property (
      cfg_done && !cfg_set |=> !o_lv_fault_status_three[`LVFS_BIT_CFG_PEND])
      else $error("config pending not cleared");

   chk_pend_fall: assert property (
      $fell(low_side_config_pending_flag_reg) |-> $past(cfg_done))
      else $error("config pending cleared without end command");

   chk_pend_kept: assert property (
      status_clear && !cfg_set && !cfg_done |=>
         o_lv_fault_status_three[`LVFS_BIT_CFG_PEND] == $past(low_side_config_pending_flag_reg))
      else $error("status clear changed config pending");

   chk_soft_reset: assert property (
      soft_reset && !serial_error |=>
         o_lv_fault_status_three[`LVFS_BIT_CFG_PEND] &&
         !o_lv_fault_status_three[`LVFS_BIT_SERIAL])
      else $error("soft reset result wrong");

   cov_status_clear: cover property (status_clear ##1 o_lv_fault_status_three[3] == 1'b0);
   cov_config_done:  cover property (cfg_done ##1 !low_side_config_pending_flag_reg);
   cov_safe_state:   cover property ($rose(o_forced_safe_state));
   cov_soft_reset:   cover property (soft_reset ##1 o_lv_fault_status_three[`LVFS_BIT_CFG_PEND]);
   cov_live_clear:   cover property (
      wipe && fly_flt ##1 o_lv_fault_status_three[`LVFS_BIT_FLYBACK]);
endmodule : lvfs_status

//--- verif/lvfs_host_model.sv
/*
 Host-side model: issues serial decoder events as one-cycle pulses.
 Assumes the caller runs it from the bench clock domain.
*/
`timescale 1ns/1ps
module lvfs_host_model (
   // Clock
   input  wire logic        i_clk,
   // Event pulses and procedure result
   output logic      [10:0] o_events,
   output logic             o_proc_ok
);
   initial begin
      o_events  = 11'h000;
      o_proc_ok = 1'b0;
   end
   // One event, high for exactly one sampling edge
   task automatic send(input int code, input logic ok);
      @(posedge i_clk);
      o_events  <= 11'h001 << code;
      o_proc_ok <= ok;
      @(posedge i_clk);
      o_events  <= 11'h000;
      o_proc_ok <= 1'b0;
   endtask : send
endmodule : lvfs_host_model

//--- verif/lv_side_fault_status_register_tb_top.sv
/*
 Self-checking bench of the low-side fault status register.
 Assumes the host model file is compiled first.
*/
`timescale 1ns/1ps
module lv_side_fault_status_register_tb_top;
   import lvfs_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic          i_clk;
   logic          i_rst_b;
   logic          lsu, csu, dtv, fly, smp, ok;
   logic [10:0]   ev;
   lvfs_byte_type st;
   logic          safe, stop;
   logic [9:0]    exp_q[$];
   logic [31:0]   lfsr_val;
   int            bad_count;
   int            checks_done;

   initial i_clk = 1'b0;
   always #25 i_clk = ~i_clk;

   lvfs_status lvfs_status_inst (
      .i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_logic_supply_uv(lsu), .i_ctrl_supply_uv(csu),
      .i_deadtime_violation(dtv), .i_flyback_fault(fly),
      .i_reset_status_command(ev[0]), .i_shutdown_pin_reset(ev[1]),
      .i_soft_reset_command(ev[2]), .i_begin_configuration_command(ev[3]),
      .i_end_configuration_command(ev[4]), .i_config_procedure_ok(ok),
      .i_crc_error(ev[5]), .i_clock_count_error(ev[6]),
      .i_command_error(ev[7]), .i_procedure_error(ev[8]),
      .i_config_timer_expired(ev[9]), .i_address_error(ev[10]),
      .o_lv_fault_status_three(st), .o_forced_safe_state(safe),
      .o_flyback_stop(stop)
   );
   lvfs_host_model lvfs_host_model_inst (
      .i_clk(i_clk), .o_events(ev), .o_proc_ok(ok)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next

   task automatic note(input logic [9:0] v);
      exp_q.push_back(v);
      @(posedge i_clk);
      smp <= 1'b1;
      @(posedge i_clk);
      smp <= 1'b0;
   endtask : note

   task automatic lv(input logic [3:0] f);
      @(posedge i_clk);
      {lsu, csu, dtv, fly} <= f;
      repeat (8) @(posedge i_clk);
   endtask : lv

   task automatic print_verdict();
      $display("Checks: %0d, mismatches: %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   // ---------------------------------------------------------------
   // Monitor: {stop, safe, status} against oldest note
   // ---------------------------------------------------------------
   always @(negedge i_clk) begin
      if (smp === 1'b1) begin
         checks_done++;
         if ({stop, safe, st} !== exp_q[0]) begin
            bad_count++;
            $display("[ERR] status exp=%h seen=%h", exp_q[0], {stop, safe, st});
         end
         void'(exp_q.pop_front());
      end
   end

   initial begin
      #(50 * 4000);
      bad_count++;
      print_verdict();
   end

   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      {lsu, csu, dtv, fly} = 4'h0;
      i_rst_b = 1'b0;
      smp = 1'b0;
      lfsr_val = 32'h7658ABE0;
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      note(10'h002);
      for (int i = 5; i < 11; i++) begin
         lvfs_host_model_inst.send(i, 1'b0);
         note(10'h00A);
         lvfs_host_model_inst.send(i % 2, 1'b0);
         note(10'h002);
      end
      lv(4'hC);
      note(10'h382);
      lv(4'h4);
      note(10'h3C2);
      lv(4'h0);
      note(10'h182);
      lvfs_host_model_inst.send(0, 1'b0);
      note(10'h002);
      lv(4'h2);
      lv(4'h0);
      note(10'h012);
      lv(4'h1);
      note(10'h013);
      lvfs_host_model_inst.send(1, 1'b0);
      note(10'h003);
      lv(4'h0);
      note(10'h002);
      lvfs_host_model_inst.send(4, 1'b1);
      note(10'h000);
      lvfs_host_model_inst.send(0, 1'b0);
      note(10'h000);
      lvfs_host_model_inst.send(3, 1'b0);
      note(10'h002);
      lvfs_host_model_inst.send(4, 1'b0);
      note(10'h002);
      lvfs_host_model_inst.send(4, 1'b1);
      lvfs_host_model_inst.send(5, 1'b0);
      note(10'h008);
      lvfs_host_model_inst.send(2, 1'b0);
      note(10'h002);
      lv(4'h2);
      lvfs_host_model_inst.send(0, 1'b0);
      note(10'h012);
      lv(4'h0);
      lvfs_host_model_inst.send(4, 1'b1);
      note(10'h010);
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      note(10'h002);
      for (int k = 0; k < 4; k++) begin
         lfsr_val = lfsr_next(lfsr_val);
         lv({3'h0, lfsr_val[0]});
         note({9'h001, lfsr_val[0]});
      end
      print_verdict();
   end
endmodule : lv_side_fault_status_register_tb_top
